// ---- rtl/rilc_ctrl.sv ----
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rilc_regs.svh"

module rilc_ctrl #(
  parameter int STAB_CYCLES = `RILC_STAB_CYC_DEF,
  parameter bit WDOG_EN = 1'b1,
  parameter bit IRQ_LEVEL = 1'b0,
  parameter bit STOP_EN = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire rilc_pkg::rilc_bus_t bus,
  output logic [7:0] rdData,
  input wire rilc_pkg::rilc_core_t core,
  input wire logic rstPin_n,
  input wire logic irqPin_n,
  input wire logic modeStrap,
  input wire logic wdogTimeout,
  input wire logic rtTickEv,
  input wire logic ctOverflowEv,
  input wire logic [3:0] t16Ev,
  input wire logic [7:0] sci1Status,
  input wire logic [7:0] sci2Status,
  input wire logic [7:0] hostStatus,
  output logic coreReset,
  output logic iBit,
  output logic vecStrobe,
  output logic [15:0] vecAddr,
  output logic stackPush,
  output logic prescalerClr,
  output rilc_pkg::rilc_run_t run,
  output logic opMode
);
  import rilc_pkg::*;

  rilc_state_t state;
  rilc_src_t vecSrc;
  rilc_src_t takeSrc;
  rilc_cause_t cause;
  logic [12:0] stabCnt;
  logic [1:0] pinLowCnt;
  logic resume;
  logic pinRst, illegalFetch, wdogRst, resetEv;
  logic boundary, takeNow, stopEnter, waitEnter;
  logic irqPrev, extLatch, extReq;
  logic hostLatch, hostReq;
  logic swiPend;
  logic [5:0] swiSnap, hwPend, gated, early;
  logic [7:0] coretimer_ctrl_status;
  logic [3:0] t16En, t16Flag, sci1En, sci2En;
  logic [7:0] hiMask;
  logic ctReq, t16Req, sci1Req, sci2Req;
  logic [7:0] rdMux;

  function automatic rilc_src_t pick(input logic [5:0] p);
    if (p[5]) begin
      return SRC_EXT;
    end else if (p[4]) begin
      return SRC_CT;
    end else if (p[3]) begin
      return SRC_HOST;
    end else if (p[2]) begin
      return SRC_T16;
    end else if (p[1]) begin
      return SRC_SERIAL_UNIT_ONE;
    end
    return SRC_SERIAL_UNIT_TWO;
  endfunction

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinLowCnt <= 2'h0;
    end else if (rstPin_n) begin
      pinLowCnt <= 2'h0;
    end else if (pinLowCnt != 2'(`RILC_PIN_LOW_CYC)) begin
      pinLowCnt <= pinLowCnt + 2'h1;
    end
  end

  always_comb begin
    pinRst = !rstPin_n && pinLowCnt == 2'(`RILC_PIN_LOW_CYC - 1) &&
             state != ST_POR && state != ST_PIN_HOLD;
    illegalFetch = state == ST_RUN && core.fetchValid &&
                   !((core.fetchAddr >= `RILC_RAM_LO && core.fetchAddr <= `RILC_RAM_HI) ||
                     (core.fetchAddr >= `RILC_ROM_LO && core.fetchAddr <= `RILC_ROM_HI));
    wdogRst = WDOG_EN && wdogTimeout && state != ST_POR && state != ST_PIN_HOLD;
    resetEv = pinRst || illegalFetch || wdogRst;
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqPrev <= 1'b1;
      extLatch <= 1'b0;
      extReq <= 1'b0;
    end else begin
      irqPrev <= irqPin_n;
      if (irqPrev && !irqPin_n) begin
        extLatch <= 1'b1;
      end else if (takeNow && takeSrc == SRC_EXT) begin
        extLatch <= 1'b0;
      end
      extReq <= extLatch || (IRQ_LEVEL && !irqPin_n);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostLatch <= 1'b0;
      hostReq <= 1'b0;
    end else begin
      hostLatch <= |(hostStatus & hiMask);
      hostReq <= hostLatch;
    end
  end

  always_comb begin
    ctReq = (coretimer_ctrl_status[`RILC_CT_OVF_FLAG] && coretimer_ctrl_status[`RILC_CT_OVF_EN]) ||
            (coretimer_ctrl_status[`RILC_CT_TICK_FLAG] && coretimer_ctrl_status[`RILC_CT_TICK_EN]);
    t16Req = |(t16Flag & t16En);
    sci1Req = |(sci1Status[`RILC_IE_HI:`RILC_IE_LO] & sci1En);
    sci2Req = |(sci2Status[`RILC_IE_HI:`RILC_IE_LO] & sci2En);
    hwPend = {extReq, ctReq, hostReq, t16Req, sci1Req, sci2Req};
  end

  // ----------------------------------------------------------------
  // Arbitration at instruction boundary
  // ----------------------------------------------------------------
  always_comb begin
    boundary = state == ST_RUN && !resetEv && (core.instrDone || resume);
    gated = iBit ? 6'h00 : hwPend;
    early = gated & swiSnap;
    takeNow = 1'b0;
    takeSrc = SRC_RESET;
    if (boundary) begin
      if (|early) begin
        takeNow = 1'b1;
        takeSrc = pick(early);
      end else if (swiPend) begin
        takeNow = 1'b1;
        takeSrc = SRC_SWI;
      end else if (|gated) begin
        takeNow = 1'b1;
        takeSrc = pick(gated);
      end
    end
    stopEnter = STOP_EN && state == ST_RUN && !resetEv && !takeNow && core.stopExec;
    waitEnter = state == ST_RUN && !resetEv && !takeNow && !core.stopExec && core.waitExec;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      swiPend <= 1'b0;
      swiSnap <= 6'h00;
    end else if (resetEv) begin
      swiPend <= 1'b0;
      swiSnap <= 6'h00;
    end else if (state == ST_RUN && core.swiFetch) begin
      swiPend <= 1'b1;
      swiSnap <= hwPend;
    end else if (takeNow && takeSrc == SRC_SWI) begin
      swiPend <= 1'b0;
      swiSnap <= 6'h00;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_POR;
      vecSrc <= SRC_RESET;
      cause <= CAUSE_POR;
      coreReset <= 1'b1;
      stabCnt <= 13'h0000;
      resume <= 1'b0;
    end else begin
      resume <= 1'b0;
      if (pinRst) begin
        state <= ST_PIN_HOLD;
        vecSrc <= SRC_RESET;
        cause <= CAUSE_PIN;
        coreReset <= 1'b1;
      end else if (illegalFetch || wdogRst) begin
        state <= ST_VEC_HI;
        vecSrc <= SRC_RESET;
        cause <= illegalFetch ? CAUSE_ILLEGAL : CAUSE_WDOG;
        coreReset <= 1'b1;
      end else begin
        unique case (state)
          ST_POR: begin
            if (stabCnt == 13'(STAB_CYCLES - 1)) begin
              stabCnt <= 13'h0000;
              state <= rstPin_n ? ST_VEC_HI : ST_PIN_HOLD;
            end else begin
              stabCnt <= stabCnt + 13'h0001;
            end
          end
          ST_PIN_HOLD: begin
            if (rstPin_n) begin
              state <= ST_VEC_HI;
            end
          end
          ST_VEC_HI: begin
            state <= ST_VEC_LO;
          end
          ST_VEC_LO: begin
            state <= ST_RUN;
            coreReset <= 1'b0;
          end
          ST_RUN: begin
            if (takeNow) begin
              state <= ST_VEC_HI;
              vecSrc <= takeSrc;
            end else if (stopEnter) begin
              state <= ST_STOP;
            end else if (waitEnter) begin
              state <= ST_WAIT;
            end
          end
          ST_STOP: begin
            if (extReq) begin
              state <= ST_STAB;
            end
          end
          ST_STAB: begin
            if (stabCnt == 13'(STAB_CYCLES - 1)) begin
              stabCnt <= 13'h0000;
              state <= ST_RUN;
              resume <= 1'b1;
            end else begin
              stabCnt <= stabCnt + 13'h0001;
            end
          end
          ST_WAIT: begin
            if (extReq || ctReq) begin
              state <= ST_RUN;
              resume <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Vector fetch, stacking and mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vecStrobe <= 1'b0;
      vecAddr <= `RILC_VEC_TOP;
      stackPush <= 1'b0;
      prescalerClr <= 1'b0;
    end else begin
      vecStrobe <= state == ST_VEC_HI || state == ST_VEC_LO;
      if (state == ST_VEC_HI || state == ST_VEC_LO) begin
        vecAddr <= `RILC_VEC_TOP - {12'h000, vecSrc, 1'b0} +
                   {15'h0000, state == ST_VEC_LO};
      end
      stackPush <= takeNow;
      prescalerClr <= stopEnter;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opMode <= 1'b0;
    end else if (state == ST_VEC_HI && vecSrc == SRC_RESET && cause != CAUSE_WDOG) begin
      opMode <= modeStrap;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iBit <= 1'b1;
    end else if (resetEv || state == ST_POR || state == ST_PIN_HOLD) begin
      iBit <= 1'b1;
    end else if (takeNow) begin
      iBit <= 1'b1;
    end else if (stopEnter || waitEnter) begin
      iBit <= 1'b0;
    end else if (core.rtiExec) begin
      iBit <= core.rtiIbit;
    end else if (core.iBitSet) begin
      iBit <= 1'b1;
    end else if (core.iBitClr) begin
      iBit <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= '0;
    end else begin
      run.oscRun <= state != ST_STOP;
      run.cpuRun <= state != ST_STOP && state != ST_STAB && state != ST_WAIT;
      run.timerRun <= state != ST_STOP && state != ST_STAB;
      run.periphRun <= state != ST_STOP && state != ST_STAB && state != ST_WAIT;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coretimer_ctrl_status <= `RILC_CORETIMER_CTRL_STATUS_RESET;
    end else if (stopEnter || (coreReset && state == ST_VEC_HI)) begin
      coretimer_ctrl_status <= {4'h0, coretimer_ctrl_status[3:0]};
    end else begin
      if (bus.wr && bus.addr == `RILC_ADDR_CORETIMER_CTRL_STATUS) begin
        // Bits 3:2 are unused and always read zero
        coretimer_ctrl_status[5:0] <= {bus.wrData[5:4], 2'h0, bus.wrData[1:0]};
      end
      coretimer_ctrl_status[`RILC_CT_OVF_FLAG] <= (ctOverflowEv && state != ST_STOP) || (coretimer_ctrl_status[7] &&
        !(bus.wr && bus.addr == `RILC_ADDR_CORETIMER_CTRL_STATUS && !bus.wrData[7]));
      coretimer_ctrl_status[`RILC_CT_TICK_FLAG] <= (rtTickEv && state != ST_STOP) || (coretimer_ctrl_status[6] &&
        !(bus.wr && bus.addr == `RILC_ADDR_CORETIMER_CTRL_STATUS && !bus.wrData[6]));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t16En <= 4'h0;
      t16Flag <= 4'h0;
    end else if (stopEnter || (coreReset && state == ST_VEC_HI)) begin
      t16En <= 4'h0;
      t16Flag <= 4'h0;
    end else begin
      if (bus.wr && bus.addr == `RILC_ADDR_T16CTRL) begin
        t16En <= bus.wrData[`RILC_IE_HI:`RILC_IE_LO];
      end
      t16Flag <= (t16Ev & {4{run.periphRun}}) | (t16Flag &
        ~((bus.wr && bus.addr == `RILC_ADDR_T16STAT) ?
        ~bus.wrData[`RILC_IE_HI:`RILC_IE_LO] : 4'h0));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sci1En <= 4'h0;
      sci2En <= 4'h0;
      hiMask <= 8'h00;
    end else if (coreReset && state == ST_VEC_HI) begin
      sci1En <= 4'h0;
      sci2En <= 4'h0;
      hiMask <= 8'h00;
    end else if (bus.wr) begin
      if (bus.addr == `RILC_ADDR_SCI1EN) begin
        sci1En <= bus.wrData[`RILC_IE_HI:`RILC_IE_LO];
      end
      if (bus.addr == `RILC_ADDR_SCI2EN) begin
        sci2En <= bus.wrData[`RILC_IE_HI:`RILC_IE_LO];
      end
      if (bus.addr == `RILC_ADDR_HIMASK) begin
        hiMask <= bus.wrData;
      end
    end
  end

  always_comb begin
    unique case (bus.addr)
      `RILC_ADDR_CORETIMER_CTRL_STATUS: rdMux = coretimer_ctrl_status;
      `RILC_ADDR_EXCSTAT: rdMux = {iBit, cause, state == ST_WAIT, state == ST_STOP,
                                   swiPend, extReq, opMode};
      `RILC_ADDR_T16CTRL: rdMux = {t16En, 4'h0};
      `RILC_ADDR_T16STAT: rdMux = {t16Flag, 4'h0};
      `RILC_ADDR_SCI1EN: rdMux = {sci1En, 4'h0};
      `RILC_ADDR_SCI1ST: rdMux = sci1Status;
      `RILC_ADDR_SCI2EN: rdMux = {sci2En, 4'h0};
      `RILC_ADDR_SCI2ST: rdMux = sci2Status;
      `RILC_ADDR_HISTAT: rdMux = hostStatus;
      `RILC_ADDR_HIMASK: rdMux = hiMask;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= bus.rd ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_illegal_reset;
    illegalFetch |=> coreReset && state == ST_VEC_HI ##1 state == ST_VEC_LO;
  endproperty
  a_illegal_reset: assert property (p_illegal_reset) else $error("illegal fetch no reset");

  property p_pin_reset;
    (!rstPin_n && pinLowCnt != 2'h0 && state != ST_POR && state != ST_PIN_HOLD)
      |=> coreReset && state == ST_PIN_HOLD;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low not reset");

  property p_pin_release;
    (state == ST_PIN_HOLD && rstPin_n && !resetEv) |=> state == ST_VEC_HI;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("late reset sequence");

  property p_reset_vec;
    (state == ST_VEC_HI && vecSrc == SRC_RESET)
      |=> vecStrobe && vecAddr == 16'h3ffe && iBit ##1 vecStrobe && vecAddr == 16'h3fff;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector order wrong");

  property p_push_mask;
    stackPush |-> iBit ##1 (state == ST_VEC_LO);
  endproperty
  a_push_mask: assert property (p_push_mask) else $error("push without mask");

  property p_masked;
    (boundary && iBit && !swiPend) |=> !stackPush;
  endproperty
  a_masked: assert property (p_masked) else $error("masked interrupt taken");

  property p_ext_first;
    (boundary && !iBit && !swiPend && extReq && ctReq && swiSnap == 6'h00)
      |=> vecSrc == SRC_EXT ##2 vecAddr == 16'h3ffb;
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("timer beat external");

  property p_stop_clear;
    stopEnter |=> !iBit && prescalerClr && coretimer_ctrl_status[7:4] == 4'h0 && t16En == 4'h0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop entry not cleared");

  property p_wait_run;
    (state == ST_WAIT && $past(state) == ST_WAIT) |-> !run.cpuRun && run.timerRun && !iBit;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("wait clocks wrong");

  property p_wdog_mode;
    (wdogRst && state == ST_RUN) |=> $stable(opMode)[*3];
  endproperty
  a_wdog_mode: assert property (p_wdog_mode) else $error("watchdog changed mode");

  c_swi_taken: cover property (takeNow && takeSrc == SRC_SWI);
  c_stop_wake: cover property (state == ST_STAB ##1 state == ST_RUN);
  c_wait_wake: cover property (state == ST_WAIT ##1 state == ST_RUN);

endmodule // rilc_ctrl

`default_nettype wire

// ---- rtl/rilc_pkg.sv ----
package rilc_pkg;

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_PIN_HOLD = 3'h1,
    ST_VEC_HI = 3'h3,
    ST_VEC_LO = 3'h2,
    ST_RUN = 3'h6,
    ST_STOP = 3'h7,
    ST_STAB = 3'h5,
    ST_WAIT = 3'h4
  } rilc_state_t;

  typedef enum logic [2:0] {
    SRC_RESET = 3'h0,
    SRC_SWI = 3'h1,
    SRC_EXT = 3'h2,
    SRC_CT = 3'h3,
    SRC_HOST = 3'h4,
    SRC_T16 = 3'h5,
    SRC_SERIAL_UNIT_ONE = 3'h6,
    SRC_SERIAL_UNIT_TWO = 3'h7
  } rilc_src_t;

  typedef enum logic [1:0] {
    CAUSE_POR = 2'h0,
    CAUSE_PIN = 2'h1,
    CAUSE_ILLEGAL = 2'h2,
    CAUSE_WDOG = 2'h3
  } rilc_cause_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } rilc_bus_t;

  typedef struct packed {
    logic instrDone;
    logic fetchValid;
    logic [15:0] fetchAddr;
    logic swiFetch;
    logic stopExec;
    logic waitExec;
    logic rtiExec;
    logic rtiIbit;
    logic iBitSet;
    logic iBitClr;
  } rilc_core_t;

  typedef struct packed {
    logic oscRun;
    logic cpuRun;
    logic timerRun;
    logic periphRun;
  } rilc_run_t;

endpackage

// ---- rtl/rilc_regs.svh ----
`ifndef RILC_REGS_SVH
`define RILC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RILC_ADDR_CORETIMER_CTRL_STATUS 6'h08
`define RILC_ADDR_EXCSTAT 6'h0a
`define RILC_ADDR_T16CTRL 6'h1c
`define RILC_ADDR_T16STAT 6'h1e
`define RILC_ADDR_SCI1EN 6'h25
`define RILC_ADDR_SCI1ST 6'h26
`define RILC_ADDR_SCI2EN 6'h2d
`define RILC_ADDR_SCI2ST 6'h2e
`define RILC_ADDR_HISTAT 6'h3c
`define RILC_ADDR_HIMASK 6'h3d

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RILC_CT_OVF_FLAG 7
`define RILC_CT_TICK_FLAG 6
`define RILC_CT_OVF_EN 5
`define RILC_CT_TICK_EN 4
`define RILC_CORETIMER_CTRL_STATUS_RESET 8'h03
`define RILC_IE_HI 7
`define RILC_IE_LO 4

// ----------------------------------------------------------------
// Address ranges and vectors
// ----------------------------------------------------------------
`define RILC_RAM_LO 16'h0050
`define RILC_RAM_HI 16'h012f
`define RILC_ROM_LO 16'h2000
`define RILC_ROM_HI 16'h3fff
`define RILC_VEC_TOP 16'h3ffe

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RILC_PIN_LOW_HALF_MCYC 3
`define RILC_CLK_PER_MCYC 1
`define RILC_PIN_LOW_CYC ((`RILC_PIN_LOW_HALF_MCYC * `RILC_CLK_PER_MCYC + 1) / 2)
`define RILC_STAB_CYC_DEF 4096

`endif

// ---- tb/rilc_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Core stand-in: instruction boundaries and vector fetch capture
// ----------------------------------------------------------------
module rilc_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire rilc_pkg::rilc_core_t cmd,
  input wire logic coreReset,
  input wire logic cpuRun,
  input wire logic vecStrobe,
  input wire logic [15:0] vecAddr,
  output rilc_pkg::rilc_core_t core,
  output logic [15:0] lastVec,
  output logic [7:0] nVec
);
  import rilc_pkg::*;
  logic [1:0] phase;
  logic second;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
    end else if (cpuRun && !coreReset) begin
      phase <= phase + 2'h1;
    end
  end
  always_comb begin
    core = cmd;
    core.instrDone = cmd.instrDone | (phase == 2'h3 && cpuRun && !coreReset);
  end
  // Second byte must be the first address with bit 0 set; a bad pair is poisoned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      second <= 1'b0;
      lastVec <= 16'h0;
      nVec <= 8'h0;
    end else if (vecStrobe && !second) begin
      second <= 1'b1;
      lastVec <= vecAddr;
    end else if (vecStrobe) begin
      second <= 1'b0;
      nVec <= nVec + 8'h1;
      if (vecAddr !== (lastVec | 16'h1)) begin
        lastVec <= 16'hffff;
      end
    end else begin
      second <= 1'b0;
    end
  end
endmodule // rilc_core_model
`default_nettype wire

// ---- tb/test_rilc_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rilc_regs.svh"
module test_rilc_ctrl;
  import rilc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  rilc_bus_t bus = '0;
  rilc_core_t cmd = '0;
  rilc_core_t core;
  rilc_run_t run;
  logic rstPin_n = 1'b1;
  logic irqPin_n = 1'b1;
  logic modeStrap = 1'b1;
  logic wdogTimeout = 1'b0;
  logic rtTickEv = 1'b0;
  logic [7:0] sci1Status = 8'h0;
  logic [7:0] hostStatus = 8'h0;
  logic ctOverflowEv = 1'b0;
  logic [3:0] t16Ev = 4'h0;
  logic [7:0] sci2Status = 8'h0;
  logic [7:0] rdData;
  logic coreReset, iBit, vecStrobe, stackPush, prescalerClr, opMode;
  logic [15:0] vecAddr, lastVec;
  logic [7:0] nVec, nHold;
  logic [7:0] nPush = 8'h0;
  logic [7:0] nStopClr = 8'h0;
  int n_mismatch = 0;
  int n_compared = 0;
  initial forever #4 clk = ~clk;
  rilc_ctrl #(.STAB_CYCLES(8)) rilc_ctrl_i (.clk(clk), .reset_n(reset_n), .bus(bus),
    .rdData(rdData), .core(core), .rstPin_n(rstPin_n), .irqPin_n(irqPin_n),
    .modeStrap(modeStrap), .wdogTimeout(wdogTimeout), .rtTickEv(rtTickEv),
    .ctOverflowEv(ctOverflowEv), .t16Ev(t16Ev), .sci1Status(sci1Status),
    .sci2Status(sci2Status),
    .hostStatus(hostStatus), .coreReset(coreReset), .iBit(iBit), .vecStrobe(vecStrobe),
    .vecAddr(vecAddr), .stackPush(stackPush), .prescalerClr(prescalerClr), .run(run),
    .opMode(opMode));
  rilc_core_model rilc_core_model_i (.clk(clk), .reset_n(reset_n), .cmd(cmd),
    .coreReset(coreReset), .cpuRun(run.cpuRun), .vecStrobe(vecStrobe), .vecAddr(vecAddr),
    .core(core), .lastVec(lastVec), .nVec(nVec));
  // Counts interrupt takes and STOP entries from their one-cycle pulses
  always @(posedge clk) begin
    if (stackPush) begin
      nPush <= nPush + 8'h1;
    end
    if (prescalerClr) begin
      nStopClr <= nStopClr + 8'h1;
    end
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wrData: 8'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk({8'h0, rdData}, {8'h0, exp});
  endtask
  task automatic op(input rilc_core_t v);
    @(posedge clk);
    cmd <= v;
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic clr();
    op('{iBitClr: 1'b1, default: '0});
  endtask
  task automatic irq();
    @(posedge clk);
    irqPin_n <= 1'b0;
    tick(2);
    irqPin_n <= 1'b1;
  endtask
  // Times out after 80 cycles; a missing vector compares as zero
  task automatic waitVec(input logic [15:0] exp);
    logic [7:0] n0;
    n0 = nVec;
    for (int i = 0; i < 80 && nVec == n0; i++) begin
      @(posedge clk);
    end
    chk((nVec == n0) ? 16'h0 : lastVec, exp);
  endtask
  task automatic tally_and_finish();
    $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    tick(6);
    reset_n <= 1'b1;
    waitVec(16'h3ffe);
    chk(16'(iBit), 16'h1);
    chk(16'(coreReset), 16'h0);
    chk(16'(opMode), 16'h1);
    rd(`RILC_ADDR_CORETIMER_CTRL_STATUS, `RILC_CORETIMER_CTRL_STATUS_RESET);
    rd(6'h3f, 8'h00);
    clr();
    irq();
    waitVec(16'h3ffa);
    chk(16'(iBit), 16'h1);
    wr(`RILC_ADDR_CORETIMER_CTRL_STATUS, 8'h13);
    @(posedge clk);
    rtTickEv <= 1'b1;
    @(posedge clk);
    rtTickEv <= 1'b0;
    irq();
    nHold = nVec;
    tick(20);
    chk({8'h0, nVec}, {8'h0, nHold});
    clr();
    waitVec(16'h3ffa);
    clr();
    waitVec(16'h3ff8);
    wr(`RILC_ADDR_CORETIMER_CTRL_STATUS, 8'h03);
    ctOverflowEv <= 1'b1;
    @(posedge clk);
    ctOverflowEv <= 1'b0;
    rd(`RILC_ADDR_CORETIMER_CTRL_STATUS, 8'h83);
    wr(`RILC_ADDR_HIMASK, 8'h80);
    hostStatus <= 8'h80;
    clr();
    waitVec(16'h3ff6);
    hostStatus <= 8'h00;
    wr(`RILC_ADDR_SCI1EN, 8'h80);
    sci1Status <= 8'h80;
    clr();
    waitVec(16'h3ff2);
    sci1Status <= 8'h00;
    wr(`RILC_ADDR_SCI2EN, 8'h10);
    sci2Status <= 8'h10;
    clr();
    waitVec(16'h3ff0);
    sci2Status <= 8'h00;
    wr(`RILC_ADDR_T16CTRL, 8'h80);
    t16Ev <= 4'h8;
    @(posedge clk);
    t16Ev <= 4'h0;
    rd(`RILC_ADDR_T16STAT, 8'h80);
    clr();
    waitVec(16'h3ff4);
    op('{swiFetch: 1'b1, default: '0});
    waitVec(16'h3ffc);
    op('{stopExec: 1'b1, default: '0});
    tick(4);
    chk(16'(run), 16'h0);
    chk(16'(iBit), 16'h0);
    irq();
    waitVec(16'h3ffa);
    rd(`RILC_ADDR_CORETIMER_CTRL_STATUS, 8'h03);
    rd(`RILC_ADDR_T16STAT, 8'h00);
    rd(`RILC_ADDR_SCI1EN, 8'h80);
    op('{waitExec: 1'b1, default: '0});
    tick(4);
    chk(16'(run), 16'ha);
    irq();
    waitVec(16'h3ffa);
    op('{fetchValid: 1'b1, fetchAddr: 16'h1000, default: '0});
    waitVec(16'h3ffe);
    @(posedge clk);
    rstPin_n <= 1'b0;
    tick(3);
    rstPin_n <= 1'b1;
    waitVec(16'h3ffe);
    modeStrap <= 1'b0;
    @(posedge clk);
    wdogTimeout <= 1'b1;
    @(posedge clk);
    wdogTimeout <= 1'b0;
    waitVec(16'h3ffe);
    chk(16'(opMode), 16'h1);
    rd(`RILC_ADDR_EXCSTAT, 8'he1);
    chk({8'h0, nPush}, 16'h000a);
    chk({8'h0, nStopClr}, 16'h0001);
    tally_and_finish();
  end
endmodule // test_rilc_ctrl
`default_nettype wire
